// >>> mrs_pkg.sv
// mrs_pkg: reset values, register offsets and pin layouts for the reset defaults block
// assumes a single 125 MHz pclk domain and an apb master for software access
package mrs_pkg;

  // ----------------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------------
  localparam logic [7:0] off_serial_tx_buffer       = 8'h00;
  localparam logic [7:0] off_fast_output_command    = 8'h04;
  localparam logic [7:0] off_fast_output_time       = 8'h08;
  localparam logic [7:0] off_fast_input_mode        = 8'h0c;
  localparam logic [7:0] off_pulse_mod_b_control    = 8'h10;
  localparam logic [7:0] off_pulse_mod_c_control    = 8'h14;
  localparam logic [7:0] off_error_correct_cs       = 8'h18;
  localparam logic [7:0] off_third_counter_value    = 8'h1c;
  localparam logic [7:0] off_io_control_four        = 8'h20;
  localparam logic [7:0] off_interrupt_priority     = 8'h24;
  localparam logic [7:0] off_transaction_server_svc = 8'h28;
  localparam logic [7:0] off_transaction_server_sel = 8'h2c;
  localparam logic [7:0] off_second_timer_capture   = 8'h30;
  localparam logic [7:0] off_program_counter        = 8'h34;
  localparam logic [7:0] off_chip_configuration     = 8'h38;
  localparam logic [7:0] off_pin_control            = 8'h3c;
  localparam logic [7:0] off_pin_status             = 8'h40;

  // ----------------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------------
  localparam logic [7:0]  rst_byte_zero    = 8'h00;
  localparam logic [15:0] rst_word_zero    = 16'h0000;
  localparam logic [7:0]  rst_fast_in_mode = 8'hff;
  localparam logic [7:0]  rst_io_ctl_four  = 8'hf0;
  localparam logic [15:0] rst_prog_counter = 16'h2080;
  localparam logic [5:0]  rst_chip_cfg_low = 6'h2f;
  localparam logic [1:0]  rst_chip_cfg_top = 2'h0;   // top bits undefined, held at zero

  // ----------------------------------------------------------------------------
  // pin control register fields
  // ----------------------------------------------------------------------------
  localparam int pc_fast_out_lsb  = 0;   // four fast output levels
  localparam int pc_pwm_a_level   = 4;   // pulse_mod_a_output level
  localparam int pc_tx_level      = 5;   // serial transmit level, inverted at the pin
  localparam int pc_port2_alt_lsb = 8;   // second port alternate selects

  // pin status fields
  localparam int ps_ecc_enable_n  = 0;
  localparam int ps_in_reset      = 1;

  // ----------------------------------------------------------------------------
  // carrier for the external pin group
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] muxed_addr_data_bus;
    logic        addr_latch;
    logic        read_strobe;
    logic        write_strobe;
  } mrs_bus_pins_t;

  typedef enum logic [1:0] {st_hold, st_release, st_run} mrs_state_t;

endpackage

// >>> mrs_reset_defaults.sv
// mrs_reset_defaults: register reset values and pin states around an external reset
// assumes apb master on pclk; reset pin and ecc enable come from outside and are synchronised
//
// Function
// - serial transmit buffer resets to 00
// - fast output command resets to 00, fast output time to 0000
// - fast input mode resets to ff
// - second and third pulse modulator controls reset to 00
// - error correction control/status resets to 00
// - third counter value resets to 0000
// - fourth io control resets to f0
// - interrupt priority resets to 00
// - transaction server service and select reset to 0000
// - second timer capture resets to 0000
// - program counter resets to 2080
// - fast output pins pulled low in reset, driven low after
// - second port stays general purpose, alternates off, pulled up
// - check bits may be driven while ecc enable is low
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ns
module mrs_reset_defaults (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   ext_reset_n,
  input  wire logic                   error_correct_enable_n,
  input  wire logic [4:0]             check_bit_in,
  output logic [4:0]                  check_bit_pins,
  output logic [4:0]                  check_bit_oe,
  output logic [3:0]                  fast_output_pins,
  output logic                        fast_output_oe,
  output logic                        fast_output_pull_down,
  output logic [7:0]                  second_port_alt_sel,
  output logic                        second_port_pull_up,
  output logic                        pulse_mod_a_output,
  output logic                        pulse_mod_a_oe,
  output logic                        serial_tx_pin,
  output logic                        serial_tx_oe,
  output mrs_pkg::mrs_bus_pins_t      bus_pins,
  output logic                        bus_oe,
  output logic                        bus_pull_up,
  output logic [15:0]                 fetch_address,
  output logic                        in_reset
);

  // ----------------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------------
  logic [2:0] rst_sync;
  logic [2:0] ecc_sync;
  logic       ext_reset_n_q;
  logic       ecc_en_n_q;

  // three stages; change taken once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_sync <= 3'h0;
      ecc_sync <= 3'h7;
    end else begin
      rst_sync <= {rst_sync[1:0], ext_reset_n};
      ecc_sync <= {ecc_sync[1:0], error_correct_enable_n};
    end
  end

  // filtered levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_reset_n_q <= 1'b0;
      ecc_en_n_q    <= 1'b1;
    end else begin
      if (rst_sync[1] == rst_sync[2]) ext_reset_n_q <= rst_sync[2];
      if (ecc_sync[1] == ecc_sync[2]) ecc_en_n_q    <= ecc_sync[2];
    end
  end

  // ----------------------------------------------------------------------------
  // reset sequencing
  // ----------------------------------------------------------------------------
  mrs_pkg::mrs_state_t state;
  logic                sys_reset;

  assign sys_reset = (state != mrs_pkg::st_run);

  // hold while pin low, one release cycle loads defaults, then run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= mrs_pkg::st_hold;
    end else begin
      case (state)
        mrs_pkg::st_hold:    if (ext_reset_n_q) state <= mrs_pkg::st_release;
        mrs_pkg::st_release: state <= ext_reset_n_q ? mrs_pkg::st_run : mrs_pkg::st_hold;
        mrs_pkg::st_run:     if (!ext_reset_n_q) state <= mrs_pkg::st_hold;
        default:             state <= mrs_pkg::st_hold;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------------
  logic wr_en;

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a[1:0] == 2'h0) && (a <= mrs_pkg::off_pin_status);
  endfunction

  // write lands only at the completing edge, where the master sees pready high
  assign wr_en = psel && penable && pready && pwrite && known_addr(paddr) && !sys_reset;

  // ----------------------------------------------------------------------------
  // special function registers
  // ----------------------------------------------------------------------------
  logic [7:0]  serial_tx_buffer;
  logic [7:0]  fast_output_command;
  logic [15:0] fast_output_time;
  logic [7:0]  fast_input_mode;
  logic [7:0]  pulse_mod_b_control;
  logic [7:0]  pulse_mod_c_control;
  logic [7:0]  error_correct_ctrl_status;
  logic [15:0] third_counter_value;
  logic [7:0]  io_control_four;
  logic [7:0]  interrupt_priority;
  logic [15:0] transaction_server_service;
  logic [15:0] transaction_server_select;
  logic [15:0] second_timer_capture;
  logic [15:0] program_counter;
  logic [7:0]  chip_configuration;
  logic [15:0] pin_control;

  // defaults held while reset is in force, software writes after
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_tx_buffer           <= mrs_pkg::rst_byte_zero;
      fast_output_command        <= mrs_pkg::rst_byte_zero;
      fast_output_time           <= mrs_pkg::rst_word_zero;
      fast_input_mode            <= mrs_pkg::rst_fast_in_mode;
      pulse_mod_b_control        <= mrs_pkg::rst_byte_zero;
      pulse_mod_c_control        <= mrs_pkg::rst_byte_zero;
      error_correct_ctrl_status  <= mrs_pkg::rst_byte_zero;
      third_counter_value        <= mrs_pkg::rst_word_zero;
      io_control_four            <= mrs_pkg::rst_io_ctl_four;
      interrupt_priority         <= mrs_pkg::rst_byte_zero;
      transaction_server_service <= mrs_pkg::rst_word_zero;
      transaction_server_select  <= mrs_pkg::rst_word_zero;
      second_timer_capture       <= mrs_pkg::rst_word_zero;
      program_counter            <= mrs_pkg::rst_prog_counter;
      chip_configuration         <= {mrs_pkg::rst_chip_cfg_top, mrs_pkg::rst_chip_cfg_low};
      pin_control                <= 16'h0000;
    end else if (sys_reset) begin
      serial_tx_buffer           <= mrs_pkg::rst_byte_zero;
      fast_output_command        <= mrs_pkg::rst_byte_zero;
      fast_output_time           <= mrs_pkg::rst_word_zero;
      fast_input_mode            <= mrs_pkg::rst_fast_in_mode;
      pulse_mod_b_control        <= mrs_pkg::rst_byte_zero;
      pulse_mod_c_control        <= mrs_pkg::rst_byte_zero;
      error_correct_ctrl_status  <= mrs_pkg::rst_byte_zero;
      third_counter_value        <= mrs_pkg::rst_word_zero;
      io_control_four            <= mrs_pkg::rst_io_ctl_four;
      interrupt_priority         <= mrs_pkg::rst_byte_zero;
      transaction_server_service <= mrs_pkg::rst_word_zero;
      transaction_server_select  <= mrs_pkg::rst_word_zero;
      second_timer_capture       <= mrs_pkg::rst_word_zero;
      program_counter            <= mrs_pkg::rst_prog_counter;
      chip_configuration         <= {mrs_pkg::rst_chip_cfg_top, mrs_pkg::rst_chip_cfg_low};
      pin_control                <= 16'h0000;
    end else if (wr_en) begin
      case (paddr)
        mrs_pkg::off_serial_tx_buffer:       serial_tx_buffer           <= pwdata[7:0];
        mrs_pkg::off_fast_output_command:    fast_output_command        <= pwdata[7:0];
        mrs_pkg::off_fast_output_time:       fast_output_time           <= pwdata[15:0];
        mrs_pkg::off_fast_input_mode:        fast_input_mode            <= pwdata[7:0];
        mrs_pkg::off_pulse_mod_b_control:    pulse_mod_b_control        <= pwdata[7:0];
        mrs_pkg::off_pulse_mod_c_control:    pulse_mod_c_control        <= pwdata[7:0];
        mrs_pkg::off_error_correct_cs:       error_correct_ctrl_status  <= pwdata[7:0];
        mrs_pkg::off_third_counter_value:    third_counter_value        <= pwdata[15:0];
        mrs_pkg::off_io_control_four:        io_control_four            <= pwdata[7:0];
        mrs_pkg::off_interrupt_priority:     interrupt_priority         <= pwdata[7:0];
        mrs_pkg::off_transaction_server_svc: transaction_server_service <= pwdata[15:0];
        mrs_pkg::off_transaction_server_sel: transaction_server_select  <= pwdata[15:0];
        mrs_pkg::off_second_timer_capture:   second_timer_capture       <= pwdata[15:0];
        mrs_pkg::off_program_counter:        program_counter            <= pwdata[15:0];
        mrs_pkg::off_chip_configuration:     chip_configuration         <= pwdata[7:0];
        mrs_pkg::off_pin_control:            pin_control                <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // apb read and answer
  // ----------------------------------------------------------------------------
  logic [31:0] rd_mux;

  // read multiplexer, narrow registers in low bits
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      mrs_pkg::off_serial_tx_buffer:       rd_mux = {24'h0, serial_tx_buffer};
      mrs_pkg::off_fast_output_command:    rd_mux = {24'h0, fast_output_command};
      mrs_pkg::off_fast_output_time:       rd_mux = {16'h0, fast_output_time};
      mrs_pkg::off_fast_input_mode:        rd_mux = {24'h0, fast_input_mode};
      mrs_pkg::off_pulse_mod_b_control:    rd_mux = {24'h0, pulse_mod_b_control};
      mrs_pkg::off_pulse_mod_c_control:    rd_mux = {24'h0, pulse_mod_c_control};
      mrs_pkg::off_error_correct_cs:       rd_mux = {24'h0, error_correct_ctrl_status};
      mrs_pkg::off_third_counter_value:    rd_mux = {16'h0, third_counter_value};
      mrs_pkg::off_io_control_four:        rd_mux = {24'h0, io_control_four};
      mrs_pkg::off_interrupt_priority:     rd_mux = {24'h0, interrupt_priority};
      mrs_pkg::off_transaction_server_svc: rd_mux = {16'h0, transaction_server_service};
      mrs_pkg::off_transaction_server_sel: rd_mux = {16'h0, transaction_server_select};
      mrs_pkg::off_second_timer_capture:   rd_mux = {16'h0, second_timer_capture};
      mrs_pkg::off_program_counter:        rd_mux = {16'h0, program_counter};
      mrs_pkg::off_chip_configuration:     rd_mux = {24'h0, chip_configuration};
      mrs_pkg::off_pin_control:            rd_mux = {16'h0, pin_control};
      mrs_pkg::off_pin_status:             rd_mux = {30'h0, sys_reset, ecc_en_n_q};
      default:                             rd_mux = 32'h0000_0000;
    endcase
  end

  // one wait state: pready rises in the first access cycle's following edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !known_addr(paddr);
      prdata  <= (psel && penable && !pready && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------------
  // pin state
  // ----------------------------------------------------------------------------
  // pin control field positions, declared ahead of their use
  localparam int pc_port2_alt_lsb = mrs_pkg::pc_port2_alt_lsb;
  localparam int pc_fast_out_lsb  = mrs_pkg::pc_fast_out_lsb;
  localparam int pc_pwm_a_level   = mrs_pkg::pc_pwm_a_level;
  localparam int pc_tx_level      = mrs_pkg::pc_tx_level;

  // pulls during reset, active drive once running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_output_pins      <= 4'h0;
      fast_output_oe        <= 1'b0;
      fast_output_pull_down <= 1'b1;
      second_port_alt_sel   <= 8'h00;
      second_port_pull_up   <= 1'b1;
      pulse_mod_a_output    <= 1'b0;
      pulse_mod_a_oe        <= 1'b0;
      serial_tx_pin         <= 1'b1;
      serial_tx_oe          <= 1'b0;
      bus_pins              <= '1;
      bus_oe                <= 1'b0;
      bus_pull_up           <= 1'b1;
      check_bit_pins        <= 5'h00;
      check_bit_oe          <= 5'h00;
      fetch_address         <= mrs_pkg::rst_prog_counter;
      in_reset              <= 1'b1;
    end else begin
      in_reset              <= sys_reset;
      fetch_address         <= program_counter;
      fast_output_pull_down <= sys_reset;
      fast_output_oe        <= !sys_reset;
      fast_output_pins      <= sys_reset ? 4'h0 : pin_control[pc_fast_out_lsb +: 4];
      second_port_pull_up   <= 1'b1;
      second_port_alt_sel   <= sys_reset ? 8'h00 : pin_control[pc_port2_alt_lsb +: 8];
      pulse_mod_a_oe        <= !sys_reset;
      pulse_mod_a_output    <= sys_reset ? 1'b0 : pin_control[pc_pwm_a_level];
      serial_tx_oe          <= !sys_reset;
      serial_tx_pin         <= sys_reset ? 1'b1 : !pin_control[pc_tx_level];
      bus_pull_up           <= sys_reset;
      bus_oe                <= !sys_reset;
      bus_pins.muxed_addr_data_bus <= sys_reset ? 16'hffff : program_counter;
      bus_pins.addr_latch   <= sys_reset;
      bus_pins.read_strobe  <= 1'b1;
      bus_pins.write_strobe <= 1'b1;
      check_bit_oe          <= (!sys_reset && !ecc_en_n_q) ? 5'h1f : 5'h00;
      check_bit_pins        <= ~check_bit_in;
    end
  end

endmodule // mrs_reset_defaults

// >>> mrs_reset_defaults_chk.sv
// mrs_reset_defaults_chk: port assertions for the reset defaults block
// assumes one pclk domain; bound onto the block at the foot of this file
`timescale 1ns/1ns
module mrs_reset_defaults_chk (
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   in_reset,
  input wire logic [3:0]             fast_output_pins,
  input wire logic                   fast_output_oe,
  input wire logic                   fast_output_pull_down,
  input wire logic [7:0]             second_port_alt_sel,
  input wire logic                   second_port_pull_up,
  input wire logic                   pulse_mod_a_output,
  input wire logic                   pulse_mod_a_oe,
  input wire logic                   serial_tx_pin,
  input wire logic                   serial_tx_oe,
  input wire mrs_pkg::mrs_bus_pins_t bus_pins,
  input wire logic                   bus_oe,
  input wire logic                   bus_pull_up,
  input wire logic [15:0]            fetch_address,
  input wire logic [4:0]             check_bit_oe
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_answer; psel && penable && !pready |=> pready; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_fo_rst; in_reset |-> fast_output_pull_down && !fast_output_oe; endproperty
  property p_fo_run; $fell(in_reset) |-> fast_output_oe && !fast_output_pull_down && fast_output_pins == 4'h0; endproperty
  property p_port2; in_reset |=> second_port_alt_sel == 8'h00 && second_port_pull_up; endproperty
  property p_bus_rst; in_reset |-> bus_pins == '1 && bus_pull_up && !bus_oe; endproperty
  property p_bus_run;
    $fell(in_reset) |-> bus_oe && fetch_address == 16'h2080 && bus_pins.muxed_addr_data_bus == 16'h2080;
  endproperty
  property p_pins_run; $fell(in_reset) |-> pulse_mod_a_oe && !pulse_mod_a_output && serial_tx_oe && serial_tx_pin; endproperty
  property p_ecc_rst; in_reset |-> check_bit_oe == 5'h00; endproperty
  a_answer: assert property (p_answer) else $error("apb answer not one cycle after access");
  a_pulse: assert property (p_pulse) else $error("pready held longer than one cycle");
  a_err: assert property (p_err) else $error("pslverr without pready");
  a_fo_rst: assert property (p_fo_rst) else $error("fast outputs not pulled down in reset");
  a_fo_run: assert property (p_fo_run) else $error("fast outputs not driven low after reset");
  a_port2: assert property (p_port2) else $error("second port not general purpose pulled up");
  a_bus_rst: assert property (p_bus_rst) else $error("bus not pulled high in reset");
  a_bus_run: assert property (p_bus_run) else $error("bus not driven from 2080 after reset");
  a_pins_run: assert property (p_pins_run) else $error("pwm or transmit pin wrong after reset");
  a_ecc_rst: assert property (p_ecc_rst) else $error("check bits driven during reset");
  c_release: cover property ($fell(in_reset));
  c_slverr: cover property (pslverr);
  c_ecc_on: cover property (check_bit_oe == 5'h1f);
endmodule // mrs_reset_defaults_chk

bind mrs_reset_defaults mrs_reset_defaults_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .in_reset(in_reset),
  .fast_output_pins(fast_output_pins), .fast_output_oe(fast_output_oe),
  .fast_output_pull_down(fast_output_pull_down), .second_port_alt_sel(second_port_alt_sel),
  .second_port_pull_up(second_port_pull_up), .pulse_mod_a_output(pulse_mod_a_output),
  .pulse_mod_a_oe(pulse_mod_a_oe), .serial_tx_pin(serial_tx_pin), .serial_tx_oe(serial_tx_oe),
  .bus_pins(bus_pins), .bus_oe(bus_oe), .bus_pull_up(bus_pull_up), .fetch_address(fetch_address),
  .check_bit_oe(check_bit_oe));

// >>> mrs_sys_model.sv
// mrs_sys_model: reset source and memory side of the check bit lines
// assumes the bench commands reset and ecc enable; pclk is the system clock
`timescale 1ns/1ns
module mrs_sys_model (
  input  wire logic       pclk,
  input  wire logic       hold_rst,
  input  wire logic       ecc_on,
  input  wire logic [4:0] dev_bits,
  input  wire logic [4:0] dev_oe,
  output logic            ext_reset_n = 1'b0,
  output logic            ecc_enable_n = 1'b1,
  output logic [4:0]      bits_wire
);
  logic [4:0] far_bits = 5'h15;
  // reset pin and enable follow the bench, far bits toggle every cycle
  always_ff @(posedge pclk) begin
    ext_reset_n  <= !hold_rst;
    ecc_enable_n <= !ecc_on;
    far_bits     <= ~far_bits;
  end
  // memory drives through a resistor, never a rail, so the device wins
  assign bits_wire = (dev_oe & dev_bits) | (~dev_oe & far_bits);
endmodule // mrs_sys_model

// >>> mrs_reset_defaults_test.sv
// mrs_reset_defaults_test: self-checking bench for the reset defaults block
// assumes the checker is bound in and the system model drives the reset pin
`timescale 1ns/1ns
module mrs_reset_defaults_test;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic hold_rst = 1'b1, ecc_on = 1'b0, ext_reset_n, ecc_n, pready, pslverr, in_reset, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, wv;
  logic [4:0] cb_pins, cb_oe, cb_wire;
  logic [3:0] fo_pins;
  logic [7:0] alt_sel;
  logic fo_oe, fo_pd, pu, pwm_a, pwm_oe, tx, tx_oe, bus_oe, bus_pu;
  logic [15:0] fetch;
  mrs_pkg::mrs_bus_pins_t bus_pins;
  int n_errors = 0, compares = 0, cycles = 0;
  always #4 pclk = ~pclk;
  mrs_sys_model i_sys (.pclk(pclk), .hold_rst(hold_rst), .ecc_on(ecc_on), .dev_bits(cb_pins),
    .dev_oe(cb_oe), .ext_reset_n(ext_reset_n), .ecc_enable_n(ecc_n), .bits_wire(cb_wire));
  mrs_reset_defaults i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_reset_n(ext_reset_n), .error_correct_enable_n(ecc_n), .check_bit_in(cb_wire),
    .check_bit_pins(cb_pins), .check_bit_oe(cb_oe), .fast_output_pins(fo_pins), .fast_output_oe(fo_oe),
    .fast_output_pull_down(fo_pd), .second_port_alt_sel(alt_sel), .second_port_pull_up(pu),
    .pulse_mod_a_output(pwm_a), .pulse_mod_a_oe(pwm_oe), .serial_tx_pin(tx), .serial_tx_oe(tx_oe),
    .bus_pins(bus_pins), .bus_oe(bus_oe), .bus_pull_up(bus_pu), .fetch_address(fetch), .in_reset(in_reset));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_of_test();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cmp_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no bound here; pready high or the bench timeout ends this wait
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  // reset value of register i, the one at byte offset 4*i
  function automatic logic [31:0] exp_default(int i);
    case (i)
      3: return 32'h0000_00ff;
      8: return 32'h0000_00f0;
      13: return 32'h0000_2080;
      14: return 32'h0000_002f;
      16: return 32'h0000_0001;  // status: running, ecc enable pin high
      default: return 32'h0;
    endcase
  endfunction
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      end_of_test();
    end
  end
  initial begin
    int n;
    void'($urandom(48));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int r = 0; r < 3; r++) begin
      repeat (6) apb(1'b1, 8'($urandom_range(15) * 4), $urandom);
      hold_rst <= 1'b1;
      repeat (8) @(posedge pclk);
      cmp_val("in_reset", 32'h1, 32'(in_reset));
      cmp_val("pull down", 32'h1, 32'(fo_pd));
      cmp_val("bus in reset", 32'h7ffff, {13'h0, bus_pins});
      cmp_val("bus pull up", 32'h1, 32'(bus_pu));
      apb(1'b1, 8'h00, 32'h0000_005a);
      hold_rst <= 1'b0;
      n = 0;
      while (in_reset !== 1'b0 && n < 40) begin
        @(posedge pclk);
        n++;
      end
      cmp_val("in_reset low", 32'h0, 32'(in_reset));
      cmp_val("fast outputs", 32'h01, {27'h0, fo_pins, fo_oe});
      cmp_val("port alt", 32'h1, {23'h0, alt_sel, pu});
      cmp_val("pwm and tx", 32'h7, {28'h0, pwm_a, pwm_oe, tx, tx_oe});
      cmp_val("bus driven", 32'h12080, {15'h0, bus_oe, fetch});
      for (int i = 0; i < 17; i++) begin
        apb(1'b0, 8'(i * 4), 32'h0);
        cmp_val($sformatf("reg %0h", i * 4), exp_default(i), (i == 14) ? (rd & 32'hffff_ff3f) : rd);
      end
      apb(1'b0, (r == 0) ? 8'h02 : 8'h44 + 8'(r * 4), 32'h0);
      cmp_val("unmapped data", 32'h0, rd);
      cmp_val("unmapped error", 32'h1, 32'(err));
      // a running write must land, so the next reset has something to undo
      wv = $urandom;
      apb(1'b1, 8'h24, wv);
      apb(1'b0, 8'h24, 32'h0);
      cmp_val("written priority", {24'h0, wv[7:0]}, rd);
      apb(1'b1, 8'h3c, 32'h0000_ff3f);
      @(posedge pclk);
      cmp_val("pins written", 32'h3ffe, {18'h0, fo_pins, alt_sel, pwm_a, tx});
      $display("test round %0d done", r);
    end
    ecc_on <= 1'b1;
    repeat (10) @(posedge pclk);
    cmp_val("check bit oe on", 32'h1f, 32'(cb_oe));
    apb(1'b0, 8'h40, 32'h0);
    cmp_val("ecc status", 32'h0, rd);
    ecc_on <= 1'b0;
    repeat (10) @(posedge pclk);
    cmp_val("check bit oe off", 32'h0, 32'(cb_oe));
    $display("test ecc enable done");
    end_of_test();
  end
endmodule // mrs_reset_defaults_test
